/* common/hmd_pkg.sv */
// host window decoder package: group codes, range table, fields, reset values
// ---------------------------------------------------------------------------
// Overview of operation
// - mode 10b legacy only, 11b both windows
// - mode 01b relocatable only, default on PCI
// - legacy select picks A0000H or B8000H base
// - legacy window mirrors relocatable register offsets
// - low legacy base: A0000H-A7FFFH writes are image data
// - high legacy base: no image writes accepted
// - port-I/O disable rejects port cycles when windows on
// - relocatable window 64 MB, upper half big endian
// - linear memory and image data offsets per half
// - configuration, overlay-stream and memory-port register ranges
// - 3Bx, 3Cx, 3Dx port groups aliased in window
// - subsystem status, advanced control, transfer-engine ranges
// - drawing groups decode in 512-byte slots
// - local peripheral bus register range
// - gaps between ranges are reserved, never routed
// - big-endian alias adds 2 to top digit
// - horizontal lock gates timing 0-5, mode bit 2
// - vertical lock gates overflow bits, vertical timing
// - compatibility bits gate attribute and palette writes
// - protect override frees overflow bits 1 and 6
package hmd_pkg;

  typedef enum logic [4:0] {
    GRP_NONE, GRP_LINEAR, GRP_IMAGE, GRP_CONFIG, GRP_STREAMS, GRP_MEMPORT,
    GRP_VGA3B, GRP_VGA3C, GRP_VGA3D, GRP_SUBSTAT, GRP_AFC, GRP_DMA,
    GRP_PATTERN, GRP_BLT, GRP_LINE2D, GRP_POLY, GRP_LINE3D, GRP_TRI, GRP_LPB
  } hmd_group_e;

  // range i routes to group i+1
  localparam int NUM_RANGES = 18;
  localparam logic [24:0] RANGE_LO [NUM_RANGES] = '{
    25'h0000000, 25'h1000000, 25'h1008000, 25'h1008180, 25'h1008200,
    25'h10083b0, 25'h10083c0, 25'h10083d0, 25'h1008504, 25'h100850c,
    25'h1008580, 25'h100a000, 25'h100a400, 25'h100a800, 25'h100ac00,
    25'h100b000, 25'h100b400, 25'h100ff00};
  localparam logic [24:0] RANGE_HI [NUM_RANGES] = '{
    25'h0ffffff, 25'h1007fff, 25'h1008043, 25'h10081ff, 25'h1008224,
    25'h10083bf, 25'h10083cf, 25'h10083df, 25'h1008507, 25'h100850f,
    25'h10085ff, 25'h100a1ff, 25'h100a5ff, 25'h100a9ff, 25'h100adff,
    25'h100b1ff, 25'h100b5ff, 25'h100ff5c};

  // window mode field values
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RELOC = 2'h1;
  localparam logic [1:0] MODE_LEGACY = 2'h2;
  localparam logic [1:0] MODE_BOTH = 2'h3;

  // legacy window placement
  localparam logic [15:0] LEG_LOW_PAGE = 16'h000a;
  localparam logic [16:0] LEG_HIGH_PAGE = 17'h00017;
  localparam logic [24:0] LEG_LOW_OFFSET = 25'h1000000;
  localparam logic [24:0] LEG_HIGH_OFFSET = 25'h1008000;
  localparam logic [24:0] PORT_ALIAS_OFFSET = 25'h1008300;
  localparam logic [7:0] PORT_PAGE = 8'h03;

  // port low bytes
  localparam logic [7:0] P_ATTR = 8'hc0;
  localparam logic [7:0] P_SEQ_IDX = 8'hc4;
  localparam logic [7:0] P_SEQ_DATA = 8'hc5;
  localparam logic [7:0] P_PAL_FIRST = 8'hc6;
  localparam logic [7:0] P_PAL_LAST = 8'hc9;
  localparam logic [7:0] P_CRTC_IDX_M = 8'hb4;
  localparam logic [7:0] P_CRTC_DATA_M = 8'hb5;
  localparam logic [7:0] P_STAT_M = 8'hba;
  localparam logic [7:0] P_CRTC_IDX = 8'hd4;
  localparam logic [7:0] P_CRTC_DATA = 8'hd5;
  localparam logic [7:0] P_STAT = 8'hda;

  // indexed register numbers
  localparam logic [7:0] IDX_HTIME_LAST = 8'h05;
  localparam logic [7:0] IDX_VTOTAL = 8'h06;
  localparam logic [7:0] IDX_OVERFLOW = 8'h07;
  localparam logic [7:0] IDX_MAXSCAN = 8'h09;
  localparam logic [7:0] IDX_VRET_START = 8'h10;
  localparam logic [7:0] IDX_VRET_END = 8'h11;
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END = 8'h16;
  localparam logic [7:0] IDX_MODE_CTL = 8'h17;
  localparam logic [7:0] IDX_COMPAT = 8'h33;
  localparam logic [7:0] IDX_TIMING_LOCK = 8'h35;
  localparam logic [7:0] IDX_WINDOW_CTL = 8'h53;
  localparam logic [7:0] IDX_BASE_HI = 8'h59;
  localparam logic [7:0] IDX_BASE_LO = 8'h5a;
  localparam logic [7:0] IDX_PORT_IO = 8'h09;
  localparam logic [4:0] ATTR_PALETTE_LAST = 5'h0f;

  // field positions
  localparam int WMODE_LSB = 3;
  localparam int LEGACY_SEL_BIT = 5;
  localparam int PIO_DIS_BIT = 7;
  localparam int HLOCK_BIT = 5;
  localparam int VLOCK_BIT = 4;
  localparam int PROT_OVR_BIT = 1;
  localparam int PAL_LOCK_BIT = 4;
  localparam int ATTR_LOCK_BIT = 6;
  localparam int VRET_PROT_BIT = 7;
  localparam int BASE_HI_LSB = 2;

  // write masks for locked fields
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_OVF_VLOCK = 8'h52;
  localparam logic [7:0] MASK_OVF_PROT = 8'hbd;
  localparam logic [7:0] MASK_MODE_HLOCK = 8'hfb;
  localparam logic [7:0] MASK_VRET_VLOCK = 8'hf0;
  localparam logic [7:0] MASK_MAXSCAN_VLOCK = 8'hdf;

  // reset values and strap timing
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_AFC = 32'h0000_0000;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

endpackage

/* common/hmd_dec_if.sv */
// offset-to-group lookup carrier between the decoder and its range table
interface hmd_dec_if;
  import hmd_pkg::*;
  logic [24:0] offset;
  hmd_group_e group;
  modport decoder (input offset, output group);
  modport user (output offset, input group);
endinterface

/* logic/hmd_group_decode.sv */
// range table lookup: window offset to register group
module hmd_group_decode
  import hmd_pkg::*;
(
  // lookup
  hmd_dec_if.decoder dec
);

  // offsets outside every range stay unrouted
  always_comb begin
    dec.group = GRP_NONE;
    for (int i = 0; i < NUM_RANGES; i++) begin
      if (dec.offset >= RANGE_LO[i] && dec.offset <= RANGE_HI[i]) begin
        dec.group = hmd_group_e'(5'(i + 1));
      end
    end
  end

endmodule

/* logic/hmd_host_decoder.sv */
// host memory/port cycle decoder with window control and write locks
module hmd_host_decoder
  import hmd_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host cycle
  input wire logic hostReq,
  input wire logic hostIsMem,
  input wire logic hostWrite,
  input wire logic [31:0] hostAddr,
  input wire logic [31:0] hostWdata,
  input wire logic [3:0] hostByteEn,
  // strap pin
  input wire logic pciBusStrap,
  // routed cycle
  output hmd_group_e fwdGroup,
  output logic fwdValid,
  output logic fwdWrite,
  output logic [24:0] fwdOffset,
  output logic fwdBigEndian,
  output logic [31:0] fwdWdata,
  output logic [3:0] fwdByteEn,
  output logic [7:0] fwdBitMask,
  // answers
  output logic portReject,
  output logic rdValid,
  output logic [31:0] rdData
);

  // ------------------------------------------------------------
  // stored state
  // ------------------------------------------------------------
  logic pciSync1_r;
  logic pciSync2_r;
  logic [1:0] strapCnt_r;
  logic strapDone_r;
  logic [7:0] windowCtl_r;
  logic [7:0] portIoReg_r;
  logic [7:0] baseHigh_r;
  logic [7:0] baseLow_r;
  logic [7:0] lockReg_r;
  logic [7:0] compatReg_r;
  logic [7:0] vretEnd_r;
  logic [7:0] crtcIdx_r;
  logic [7:0] seqIdx_r;
  logic attrPhase_r;
  logic [4:0] attrIdx_r;
  logic pioRejSeen_r;
  logic [31:0] afc_r;

  // ------------------------------------------------------------
  // window hit
  // ------------------------------------------------------------
  logic [1:0] mode;
  logic legacyHigh;
  logic mmioOn;
  logic pioDisable;
  logic legLowHit;
  logic legHighHit;
  logic relocHit;
  logic memHit;
  logic bigEnd;
  logic [7:0] portLow;
  logic vgaPort;
  logic portOk;
  logic claim;
  logic rejectNow;
  hmd_group_e grp;
  hmd_dec_if decIf ();

  assign mode = windowCtl_r[WMODE_LSB +: 2];
  assign legacyHigh = windowCtl_r[LEGACY_SEL_BIT];
  assign mmioOn = (mode != MODE_OFF);
  assign pioDisable = portIoReg_r[PIO_DIS_BIT];

  // legacy decode wins where both windows overlap
  assign legLowHit = hostIsMem && mode[1] && !legacyHigh
                     && hostAddr[31:16] == LEG_LOW_PAGE;
  assign legHighHit = hostIsMem && mode[1] && legacyHigh
                      && hostAddr[31:15] == LEG_HIGH_PAGE;
  // only the top six base bits take part
  assign relocHit = hostIsMem && mode[0]
                    && hostAddr[31:26] == baseHigh_r[7:BASE_HI_LSB];
  assign memHit = legLowHit || legHighHit || relocHit;
  assign portLow = hostAddr[7:0];
  assign vgaPort = !hostIsMem && hostAddr[15:8] == PORT_PAGE;

  always_comb begin
    decIf.offset = PORT_ALIAS_OFFSET | {17'h0, portLow};
    bigEnd = 1'b0;
    if (legLowHit) begin
      decIf.offset = LEG_LOW_OFFSET | {9'h0, hostAddr[15:0]};
    end else if (legHighHit) begin
      decIf.offset = LEG_HIGH_OFFSET | {10'h0, hostAddr[14:0]};
    end else if (relocHit) begin
      decIf.offset = hostAddr[24:0];
      bigEnd = hostAddr[25];
    end
  end

  hmd_group_decode u_decode (
    .dec(decIf)
  );

  assign grp = decIf.group;
  assign portOk = !(mmioOn && pioDisable);
  assign rejectNow = hostReq && vgaPort && !portOk;

  // legacy image range takes writes only, assumed doublewords
  always_comb begin
    claim = 1'b0;
    if (hostReq && grp != GRP_NONE) begin
      if (memHit) begin
        claim = !(legLowHit && grp == GRP_IMAGE && !hostWrite);
      end else if (vgaPort && portOk) begin
        claim = (grp == GRP_VGA3B || grp == GRP_VGA3C || grp == GRP_VGA3D);
      end
    end
  end

  // ------------------------------------------------------------
  // byte-wide indexed port access
  // ------------------------------------------------------------
  logic [7:0] dataByte;
  logic vgaWr;
  logic vgaRd;
  logic crtcIdxWr;
  logic crtcDataWr;
  logic seqIdxWr;
  logic seqDataWr;
  logic attrWr;
  logic palWr;
  logic statRd;
  logic [7:0] regPort;
  logic hLock;
  logic vLock;

  // the addressed port is the byte lane that carries it
  assign dataByte = hostWdata[{hostAddr[1:0], 3'b000} +: 8];
  assign regPort = decIf.offset[7:0];
  assign vgaWr = claim && hostWrite
                 && (grp == GRP_VGA3B || grp == GRP_VGA3C || grp == GRP_VGA3D);
  assign vgaRd = claim && !hostWrite
                 && (grp == GRP_VGA3B || grp == GRP_VGA3C || grp == GRP_VGA3D);
  assign crtcIdxWr = vgaWr && (regPort == P_CRTC_IDX || regPort == P_CRTC_IDX_M);
  assign crtcDataWr = vgaWr && (regPort == P_CRTC_DATA || regPort == P_CRTC_DATA_M);
  assign seqIdxWr = vgaWr && regPort == P_SEQ_IDX;
  assign seqDataWr = vgaWr && regPort == P_SEQ_DATA;
  assign attrWr = vgaWr && regPort == P_ATTR;
  assign palWr = vgaWr && regPort >= P_PAL_FIRST && regPort <= P_PAL_LAST;
  assign statRd = vgaRd && (regPort == P_STAT || regPort == P_STAT_M);
  assign hLock = lockReg_r[HLOCK_BIT];
  assign vLock = lockReg_r[VLOCK_BIT];

  // ------------------------------------------------------------
  // write protection mask
  // ------------------------------------------------------------
  logic [7:0] bitMask;

  always_comb begin
    bitMask = MASK_ALL;
    if (crtcDataWr) begin
      case (crtcIdx_r)
        IDX_MODE_CTL: if (hLock) bitMask = MASK_MODE_HLOCK;
        IDX_OVERFLOW: begin
          if (vLock) bitMask = MASK_OVF_VLOCK;
          if (vretEnd_r[VRET_PROT_BIT] && !compatReg_r[PROT_OVR_BIT]) begin
            bitMask = bitMask & MASK_OVF_PROT;
          end
        end
        IDX_VTOTAL, IDX_VRET_START,
        IDX_VBLANK_START, IDX_VBLANK_END: if (vLock) bitMask = 8'h00;
        IDX_VRET_END: if (vLock) bitMask = MASK_VRET_VLOCK;
        IDX_MAXSCAN: if (vLock) bitMask = MASK_MAXSCAN_VLOCK;
        default: if (crtcIdx_r <= IDX_HTIME_LAST && hLock) bitMask = 8'h00;
      endcase
    end
    if (attrWr && attrPhase_r && attrIdx_r <= ATTR_PALETTE_LAST
        && compatReg_r[ATTR_LOCK_BIT]) begin
      bitMask = 8'h00;
    end
    if (palWr && compatReg_r[PAL_LOCK_BIT]) begin
      bitMask = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // strap synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pciSync1_r <= 1'b0;
      pciSync2_r <= 1'b0;
    end else begin
      pciSync1_r <= pciBusStrap;
      pciSync2_r <= pciSync1_r;
    end
  end

  // ------------------------------------------------------------
  // extension registers
  // ------------------------------------------------------------
  // strap load waits out the synchroniser after release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strapCnt_r <= 2'h0;
      strapDone_r <= 1'b0;
      windowCtl_r <= RST_BYTE;
      baseHigh_r <= RST_BYTE;
      baseLow_r <= RST_BYTE;
      lockReg_r <= RST_BYTE;
      compatReg_r <= RST_BYTE;
      portIoReg_r <= RST_BYTE;
    end else begin
      if (!strapDone_r) begin
        strapCnt_r <= strapCnt_r + 2'h1;
      end
      if (!strapDone_r && strapCnt_r == STRAP_WAIT) begin
        strapDone_r <= 1'b1;
        windowCtl_r[WMODE_LSB +: 2] <= pciSync2_r ? MODE_RELOC : MODE_OFF;
      end else if (crtcDataWr && crtcIdx_r == IDX_WINDOW_CTL) begin
        windowCtl_r <= dataByte;
      end
      if (crtcDataWr && crtcIdx_r == IDX_BASE_HI) baseHigh_r <= dataByte;
      if (crtcDataWr && crtcIdx_r == IDX_BASE_LO) baseLow_r <= dataByte;
      if (crtcDataWr && crtcIdx_r == IDX_TIMING_LOCK) lockReg_r <= dataByte;
      if (crtcDataWr && crtcIdx_r == IDX_COMPAT) compatReg_r <= dataByte;
      if (seqDataWr && seqIdx_r == IDX_PORT_IO) portIoReg_r <= dataByte;
    end
  end

  // ------------------------------------------------------------
  // index and attribute flip-flop
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crtcIdx_r <= RST_BYTE;
      seqIdx_r <= RST_BYTE;
      attrPhase_r <= 1'b0;
      attrIdx_r <= 5'h0;
      vretEnd_r <= RST_BYTE;
    end else begin
      if (crtcIdxWr) crtcIdx_r <= dataByte;
      if (seqIdxWr) seqIdx_r <= dataByte;
      // status read puts the attribute port back to index phase
      if (statRd) begin
        attrPhase_r <= 1'b0;
      end else if (attrWr) begin
        attrPhase_r <= !attrPhase_r;
        if (!attrPhase_r) attrIdx_r <= dataByte[4:0];
      end
      if (crtcDataWr && crtcIdx_r == IDX_VRET_END) begin
        vretEnd_r <= (vretEnd_r & ~bitMask) | (dataByte & bitMask);
      end
    end
  end

  // ------------------------------------------------------------
  // status and advanced function control
  // ------------------------------------------------------------
  logic statWr;
  logic afcWr;

  assign statWr = claim && hostWrite && grp == GRP_SUBSTAT;
  assign afcWr = claim && hostWrite && grp == GRP_AFC;

  // a reject in the clearing cycle keeps the flag set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pioRejSeen_r <= 1'b0;
      afc_r <= RST_AFC;
    end else begin
      if (rejectNow) begin
        pioRejSeen_r <= 1'b1;
      end else if (statWr && hostByteEn[0] && hostWdata[0]) begin
        pioRejSeen_r <= 1'b0;
      end
      for (int b = 0; b < 4; b++) begin
        if (afcWr && hostByteEn[b]) afc_r[8*b +: 8] <= hostWdata[8*b +: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // read data for registers held here
  // ------------------------------------------------------------
  logic ownRd;
  logic [7:0] extByte;
  logic [31:0] rdNxt;

  always_comb begin
    extByte = RST_BYTE;
    ownRd = 1'b0;
    if (vgaRd && (regPort == P_CRTC_DATA || regPort == P_CRTC_DATA_M)) begin
      ownRd = 1'b1;
      case (crtcIdx_r)
        IDX_WINDOW_CTL: extByte = windowCtl_r;
        IDX_BASE_HI: extByte = baseHigh_r;
        IDX_BASE_LO: extByte = baseLow_r;
        IDX_TIMING_LOCK: extByte = lockReg_r;
        IDX_COMPAT: extByte = compatReg_r;
        default: ownRd = 1'b0;
      endcase
    end else if (vgaRd && regPort == P_SEQ_DATA && seqIdx_r == IDX_PORT_IO) begin
      ownRd = 1'b1;
      extByte = portIoReg_r;
    end
    rdNxt = {24'h0, extByte} << {hostAddr[1:0], 3'b000};
    if (claim && !hostWrite && grp == GRP_SUBSTAT) begin
      ownRd = 1'b1;
      rdNxt = {26'h0, pioDisable, legacyHigh, mode, strapDone_r, pioRejSeen_r};
    end else if (claim && !hostWrite && grp == GRP_AFC) begin
      ownRd = 1'b1;
      rdNxt = afc_r;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fwdValid <= 1'b0;
      fwdWrite <= 1'b0;
      fwdGroup <= GRP_NONE;
      fwdOffset <= 25'h0;
      fwdBigEndian <= 1'b0;
      fwdWdata <= 32'h0;
      fwdByteEn <= 4'h0;
      fwdBitMask <= MASK_ALL;
      portReject <= 1'b0;
      rdValid <= 1'b0;
      rdData <= 32'h0;
    end else begin
      fwdValid <= claim;
      fwdWrite <= hostWrite && claim;
      fwdGroup <= claim ? grp : GRP_NONE;
      fwdOffset <= decIf.offset;
      fwdBigEndian <= bigEnd && claim;
      fwdWdata <= hostWdata;
      fwdByteEn <= hostByteEn;
      fwdBitMask <= bitMask;
      portReject <= rejectNow;
      rdValid <= ownRd;
      rdData <= ownRd ? rdNxt : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_strap_pci;
    !strapDone_r && strapCnt_r == STRAP_WAIT && pciSync2_r ##1 strapDone_r;
  endsequence

  sequence s_hidx_write;
    crtcIdxWr && dataByte <= IDX_HTIME_LAST ##1 crtcDataWr && hLock;
  endsequence

  a_pci_default_mode: assert property (s_strap_pci |-> mode == MODE_RELOC)
    else $error("pci strap did not select relocatable window");
  a_no_window_claim: assert property (
    hostReq && hostIsMem && mode == MODE_OFF |=> !fwdValid)
    else $error("memory cycle claimed with windows off");
  a_port_reject_hit: assert property (
    hostReq && vgaPort && mmioOn && pioDisable |=> portReject && !fwdValid)
    else $error("port cycle not rejected");
  a_legacy_image_wr: assert property (
    hostReq && hostWrite && legLowHit && !hostAddr[15]
    |=> fwdValid && fwdGroup == GRP_IMAGE)
    else $error("legacy image write not routed");
  a_high_base_noimg: assert property (
    hostReq && hostIsMem && mode == MODE_LEGACY && legacyHigh
    && hostAddr[31:15] == {LEG_LOW_PAGE, 1'b0} |=> !fwdValid)
    else $error("image range claimed at high legacy base");
  a_big_endian_half: assert property (
    claim && relocHit && !legLowHit && !legHighHit
    |=> fwdBigEndian == $past(hostAddr[25]))
    else $error("endian half wrong");
  a_hlock_timing: assert property (s_hidx_write |=> fwdBitMask == 8'h00)
    else $error("horizontal timing write not blocked");
  a_vlock_overflow: assert property (
    crtcDataWr && crtcIdx_r == IDX_OVERFLOW && vLock |=> !fwdBitMask[0]
    && !fwdBitMask[7] && fwdBitMask[4])
    else $error("overflow lock mask wrong");
  a_palette_lock: assert property (
    palWr && compatReg_r[PAL_LOCK_BIT] |=> fwdValid && fwdBitMask == 8'h00)
    else $error("palette write not blocked");
  a_reserved_gap: assert property (fwdValid |-> fwdGroup != GRP_NONE)
    else $error("unrouted cycle claimed");

endmodule

/* tb/hmd_host_model.sv */
// host bus master model issuing memory and port cycles
module hmd_host_model (
  // clock
  input wire logic clk_sys,
  // host cycle
  output logic hostReq,
  output logic hostIsMem,
  output logic hostWrite,
  output logic [31:0] hostAddr,
  output logic [31:0] hostWdata,
  output logic [3:0] hostByteEn
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    hostReq = 1'b0;
    hostIsMem = 1'b0;
    hostWrite = 1'b0;
    hostAddr = 32'h0000_0000;
    hostWdata = 32'h0000_0000;
    hostByteEn = 4'h0;
  end

  // ---------------------------------------------------------------
  // one cycle, launched and answered on falling edges
  // ---------------------------------------------------------------
  task automatic put(input logic mem, input logic wr, input logic [31:0] a,
                     input logic [7:0] d);
    hostReq = 1'b1;
    hostIsMem = mem;
    hostWrite = wr;
    hostAddr = a;
    hostWdata = mem ? {4{d}} : 32'(d) << (8 * a[1:0]);
    hostByteEn = mem ? 4'hf : 4'h1 << a[1:0];
  endtask

  task automatic idle();
    hostReq = 1'b0;
    // released address and data lines never keep the old value
    hostAddr = ~hostAddr;
    hostWdata = ~hostWdata;
  endtask

  task automatic cyc(input logic mem, input logic wr, input logic [31:0] a,
                     input logic [7:0] d);
    @(negedge clk_sys);
    put(mem, wr, a, d);
    @(negedge clk_sys);
    idle();
  endtask

  // index and data back to back, no idle clock between them
  task automatic pair(input logic [31:0] a, input logic [7:0] idx, input logic [7:0] d);
    @(negedge clk_sys);
    put(1'b0, 1'b1, a, idx);
    @(negedge clk_sys);
    put(1'b0, 1'b1, a + 32'h1, d);
    @(negedge clk_sys);
    idle();
  endtask
endmodule

/* tb/hmd_host_decoder_tb.sv */
// self-checking bench for the host window decoder
module hmd_host_decoder_tb import hmd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys, rst_n, pciBusStrap;
  logic hostReq, hostIsMem, hostWrite;
  logic [31:0] hostAddr, hostWdata, rdData, fwdWdata;
  logic [3:0] hostByteEn, fwdByteEn;
  hmd_group_e fwdGroup;
  logic fwdValid, fwdWrite, fwdBigEndian, portReject, rdValid;
  logic [24:0] fwdOffset;
  logic [7:0] fwdBitMask;
  int errorCnt = 0;
  int compares = 0;
  logic [31:0] tAddr [20] = '{32'h0000010, 32'h1000000, 32'h1008000, 32'h10081ff,
    32'h1008224, 32'h10083b4, 32'h10083c0, 32'h10083d0, 32'h1008504, 32'h100850c,
    32'h10085ff, 32'h100a1ff, 32'h100a400, 32'h100a800, 32'h100ac00, 32'h100b000,
    32'h100b5ff, 32'h100ff5c, 32'h1008044, 32'h100ff60};
  hmd_group_e tGrp [20] = '{GRP_LINEAR, GRP_IMAGE, GRP_CONFIG, GRP_STREAMS,
    GRP_MEMPORT, GRP_VGA3B, GRP_VGA3C, GRP_VGA3D, GRP_SUBSTAT, GRP_AFC, GRP_DMA,
    GRP_PATTERN, GRP_BLT, GRP_LINE2D, GRP_POLY, GRP_LINE3D, GRP_TRI, GRP_LPB,
    GRP_NONE, GRP_NONE};

  hmd_host_decoder DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hostReq(hostReq),
    .hostIsMem(hostIsMem), .hostWrite(hostWrite), .hostAddr(hostAddr),
    .hostWdata(hostWdata), .hostByteEn(hostByteEn), .pciBusStrap(pciBusStrap),
    .fwdGroup(fwdGroup), .fwdValid(fwdValid), .fwdWrite(fwdWrite),
    .fwdOffset(fwdOffset), .fwdBigEndian(fwdBigEndian), .fwdWdata(fwdWdata),
    .fwdByteEn(fwdByteEn), .fwdBitMask(fwdBitMask), .portReject(portReject),
    .rdValid(rdValid), .rdData(rdData));

  hmd_host_model HOST (.clk_sys(clk_sys), .hostReq(hostReq), .hostIsMem(hostIsMem),
    .hostWrite(hostWrite), .hostAddr(hostAddr), .hostWdata(hostWdata),
    .hostByteEn(hostByteEn));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // index then data byte of an indexed port pair
  task automatic crw(input logic [15:0] p, input logic [7:0] idx, input logic [7:0] d);
    HOST.pair({16'h0000, p}, idx, d);
  endtask

  task automatic mem(input logic wr, input logic [31:0] a, input hmd_group_e g);
    HOST.cyc(1'b1, wr, a, 8'h00);
    chk(32'(fwdGroup), 32'(g));
    chk(32'(fwdValid), 32'(g != GRP_NONE));
    chk(32'(fwdWrite), 32'(wr && g != GRP_NONE));
    chk(32'(fwdByteEn), 32'hf);
  endtask

  task automatic closeOut();
    $display("compares=%0d errors=%0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    errorCnt++;
    closeOut();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    pciBusStrap = 1'b1;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    HOST.cyc(1'b1, 1'b0, 32'h1008504, 8'h00);
    chk(32'(rdValid), 32'h1);
    chk(rdData, 32'h6);
    $display("test strap done");
    for (int b = 0; b < 2; b++) begin
      for (int i = 0; i < 20; i++) begin
        mem(1'b1, tAddr[i] | (32'(b) << 25), tGrp[i]);
        if (tGrp[i] != GRP_NONE) begin
          chk(32'(fwdOffset), 32'(tAddr[i][24:0]));
          chk(32'(fwdBigEndian), 32'(b));
        end
      end
    end
    $display("test relocatable map done");
    crw(16'h03d4, 8'h53, 8'h18);
    mem(1'b1, 32'h000a0100, GRP_IMAGE);
    chk(32'(fwdOffset), 32'h1000100);
    mem(1'b0, 32'h000a0100, GRP_NONE);
    mem(1'b0, 32'h000a8000, GRP_CONFIG);
    crw(16'h03d4, 8'h53, 8'h38);
    mem(1'b0, 32'h000b8000, GRP_CONFIG);
    crw(16'h03d4, 8'h53, 8'h30);
    mem(1'b1, 32'h000a0100, GRP_NONE);
    mem(1'b0, 32'h01008000, GRP_NONE);
    mem(1'b0, 32'h000b8504, GRP_SUBSTAT);
    crw(16'h03d4, 8'h53, 8'h00);
    mem(1'b0, 32'h000b8000, GRP_NONE);
    mem(1'b0, 32'h01008000, GRP_NONE);
    crw(16'h03d4, 8'h53, 8'h08);
    $display("test legacy window done");
    crw(16'h03c4, 8'h09, 8'h80);
    HOST.cyc(1'b0, 1'b0, 32'h3d5, 8'h00);
    chk(32'(portReject), 32'h1);
    chk(32'(fwdValid), 32'h0);
    HOST.cyc(1'b1, 1'b1, 32'h10083c5, 8'h00);
    HOST.cyc(1'b0, 1'b0, 32'h3d5, 8'h00);
    chk(32'(portReject), 32'h0);
    chk(rdData, 32'h0000_0800);
    HOST.cyc(1'b1, 1'b0, 32'h1008504, 8'h00);
    chk(rdData, 32'h7);
    HOST.cyc(1'b1, 1'b1, 32'h1008504, 8'h01);
    HOST.cyc(1'b1, 1'b0, 32'h1008504, 8'h00);
    chk(rdData, 32'h6);
    HOST.cyc(1'b1, 1'b1, 32'h100850c, 8'h5a);
    HOST.cyc(1'b1, 1'b0, 32'h100850c, 8'h00);
    chk(rdData, 32'h5a5a5a5a);
    $display("test port disable done");
    crw(16'h03d4, 8'h35, 8'h20);
    crw(16'h03d4, 8'h17, 8'hff);
    chk(32'(fwdBitMask), 32'hfb);
    crw(16'h03d4, 8'h05, 8'hff);
    chk(32'(fwdBitMask), 32'h00);
    crw(16'h03d4, 8'h35, 8'h10);
    crw(16'h03d4, 8'h07, 8'hff);
    chk(32'(fwdBitMask), 32'h52);
    crw(16'h03d4, 8'h06, 8'hff);
    chk(32'(fwdBitMask), 32'h00);
    crw(16'h03d4, 8'h35, 8'h00);
    crw(16'h03d4, 8'h11, 8'h80);
    crw(16'h03d4, 8'h07, 8'hff);
    chk(32'(fwdBitMask), 32'hbd);
    crw(16'h03d4, 8'h33, 8'h02);
    crw(16'h03d4, 8'h07, 8'hff);
    chk(32'(fwdBitMask), 32'hff);
    crw(16'h03d4, 8'h33, 8'h10);
    HOST.cyc(1'b0, 1'b1, 32'h3c8, 8'hff);
    chk(32'(fwdBitMask), 32'h00);
    chk(fwdWdata, 32'h0000_00ff);
    crw(16'h03d4, 8'h33, 8'h40);
    HOST.cyc(1'b0, 1'b0, 32'h3da, 8'h00);
    HOST.cyc(1'b0, 1'b1, 32'h3c0, 8'h02);
    HOST.cyc(1'b0, 1'b1, 32'h3c0, 8'hff);
    chk(32'(fwdBitMask), 32'h00);
    $display("test locks done");
    closeOut();
  end
endmodule
